// ===== hdl/pfs_port_mux_top.sv
// output function select for general ports 8 to 12 with an apb register slave
//
// Operation
// - code zero routes latch, others peripheral
// - direction one drives pin as output
// - direction zero makes pin input only
// - port 9 selects writable right after unlock
// - port 9 analog: code 80h, direction zero
// - port 10 all zeros: plain port
// - port 10 analog input: 80h, direction zero
// - open-drain bit stops high drive
// - port 8 pins 0-2 peripheral routing
// - port 8 selects only pins 0-4,6,7
// - port 9 code 011b routes serial 3/4
// - port 9 simplified tx and group 2
// - port 11 serial 8 and group 1
// - port 12 code 011b routes serial 6
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pfs_map.svh"

module pfs_port_mux_top (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // pins, index port*8+pin, ports 8..12
  input  wire logic [39:0] PORT_PIN_IN,
  output logic [39:0]      PORT_PIN_OUT,
  output logic [39:0]      PORT_PIN_OE_OUT,
  output logic [39:0]      ANALOG_SEL_OUT,
  // timer, motor drive, can
  input  wire logic        TIMER_A4_OUTPUT_IN,
  input  wire logic        MOTOR_PHASE_U_IN,
  input  wire logic        MOTOR_PHASE_U_INV_IN,
  input  wire logic        CAN_CONTROLLER_TX_IN,
  // serial 3
  input  wire logic        SERIAL3_CLOCK_OUT_IN,
  input  wire logic        SERIAL3_BUS_CLOCK_OUT_IN,
  input  wire logic        SERIAL3_TRANSMIT_IN,
  input  wire logic        SERIAL3_SIMPLIFIED_TX_IN,
  input  wire logic        SERIAL3_REQUEST_TO_SEND_IN,
  // serial 4
  input  wire logic        SERIAL4_CLOCK_OUT_IN,
  input  wire logic        SERIAL4_BUS_CLOCK_OUT_IN,
  input  wire logic        SERIAL4_TRANSMIT_IN,
  input  wire logic        SERIAL4_SIMPLIFIED_TX_IN,
  input  wire logic        SERIAL4_REQUEST_TO_SEND_IN,
  // serial 5
  input  wire logic        SERIAL5_BUS_CLOCK_OUT_IN,
  input  wire logic        SERIAL5_SIMPLIFIED_TX_IN,
  input  wire logic        SERIAL5_REQUEST_TO_SEND_IN,
  // serial 6
  input  wire logic        SERIAL6_TRANSMIT_IN,
  input  wire logic        SERIAL6_CLOCK_OUT_IN,
  input  wire logic        SERIAL6_BUS_CLOCK_OUT_IN,
  input  wire logic        SERIAL6_SIMPLIFIED_TX_IN,
  input  wire logic        SERIAL6_REQUEST_TO_SEND_IN,
  // serial 8
  input  wire logic        SERIAL8_TRANSMIT_IN,
  input  wire logic        SERIAL8_CLOCK_OUT_IN,
  input  wire logic        SERIAL8_REQUEST_TO_SEND_IN,
  // intelligent io groups
  input  wire logic [7:0]  INTELLIGENT_IO_GROUP1_IN,
  input  wire logic        IO_GROUP2_OUT_IN
);

  // ==========================================================================
  // decode helpers
  function automatic logic sel_exists(input logic [2:0] port, input logic [2:0] pin);
    sel_exists = !((port == `PFS_P8 && pin == `PFS_P8_NOSEL_PIN) ||
                   (port == `PFS_P11 && pin > `PFS_P11_LAST_PIN));
  endfunction

  function automatic logic [7:0] pin_mask(input logic [2:0] port);
    pin_mask = (port == `PFS_P11) ? `PFS_P11_MASK : `PFS_FULL_MASK;
  endfunction

  // port 10 has no open-drain; port 8 keeps it for its tolerant pins
  function automatic logic [7:0] od_mask(input logic [2:0] port);
    od_mask = (port == `PFS_P10) ? `PFS_NO_OD_MASK : pin_mask(port);
  endfunction

  function automatic pfs_pkg::pfs_dec_s decode(input logic [11:0] a);
    logic [11:0] off;
    off        = 12'h000;
    decode.grp  = pfs_pkg::GRP_NONE;
    decode.port = 3'h0;
    decode.pin  = 3'h0;
    if ((a & `PFS_ALIGN_MASK) == 12'h000) begin
      if (a < `PFS_SEL_BASE + `PFS_SEL_SPAN) begin
        off         = a - `PFS_SEL_BASE;
        decode.port = off[7:5];
        decode.pin  = off[4:2];
        if (sel_exists(off[7:5], off[4:2])) begin
          decode.grp = pfs_pkg::GRP_SEL;
        end
      end else if (a == `PFS_PROT_ADDR) begin
        decode.grp = pfs_pkg::GRP_PROT;
      end else if (a >= `PFS_LATCH_BASE && a < `PFS_PIN_BASE + `PFS_GRP_SPAN) begin
        off         = (a - `PFS_LATCH_BASE) & (`PFS_DIR_BASE - `PFS_LATCH_BASE - 12'h001);
        decode.port = off[4:2];
        if (off < `PFS_GRP_SPAN) begin
          case (a - off)
            `PFS_LATCH_BASE: decode.grp = pfs_pkg::GRP_LATCH;
            `PFS_DIR_BASE:   decode.grp = pfs_pkg::GRP_DIR;
            `PFS_OD_BASE:    decode.grp = pfs_pkg::GRP_OD;
            `PFS_PIN_BASE:   decode.grp = pfs_pkg::GRP_PIN;
            default:         decode.grp = pfs_pkg::GRP_NONE;
          endcase
        end
      end
    end
  endfunction

  // ==========================================================================
  // state
  pfs_pkg::pfs_state_s q;
  pfs_pkg::pfs_state_s d;
  pfs_pkg::pfs_dec_s   dec;

  logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0][7:0] cand;
  logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      mux_out;
  logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      mux_oe;
  logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      ana_flat;
  logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      pin_in;
  logic                                        setup;
  logic                                        access;
  logic                                        wr_go;
  logic                                        p9_locked;

  assign pin_in    = PORT_PIN_IN;
  assign dec       = decode(PADDR_IN);
  assign setup     = PSEL_IN & ~PENABLE_IN;
  assign access    = PSEL_IN & PENABLE_IN;
  assign wr_go     = access & PWRITE_IN;
  // a blocked port 9 write is refused with an error instead of vanishing
  assign p9_locked = PWRITE_IN && dec.grp == pfs_pkg::GRP_SEL && dec.port == `PFS_P9 &&
                     !q.prot;

  // ==========================================================================
  // peripheral candidates, indexed port, pin, code; unlisted entries stay low
  always_comb begin
    cand = '0;
    cand[`PFS_P8][0][`PFS_CODE_TIMER]   = TIMER_A4_OUTPUT_IN;
    cand[`PFS_P8][0][`PFS_CODE_MOTOR]   = MOTOR_PHASE_U_IN;
    cand[`PFS_P8][0][`PFS_CODE_SERIAL]  = SERIAL5_BUS_CLOCK_OUT_IN;
    cand[`PFS_P8][0][`PFS_CODE_STX]     = SERIAL5_SIMPLIFIED_TX_IN;
    cand[`PFS_P8][1][`PFS_CODE_MOTOR]   = MOTOR_PHASE_U_INV_IN;
    cand[`PFS_P8][1][`PFS_CODE_SERIAL]  = SERIAL5_REQUEST_TO_SEND_IN;
    cand[`PFS_P8][1][`PFS_CODE_IIO]     = INTELLIGENT_IO_GROUP1_IN[5];
    cand[`PFS_P8][2][`PFS_CODE_ALT]     = CAN_CONTROLLER_TX_IN;
    cand[`PFS_P9][0][`PFS_CODE_SERIAL]  = SERIAL3_CLOCK_OUT_IN;
    cand[`PFS_P9][1][`PFS_CODE_SERIAL]  = SERIAL3_BUS_CLOCK_OUT_IN;
    cand[`PFS_P9][2][`PFS_CODE_SERIAL]  = SERIAL3_TRANSMIT_IN;
    cand[`PFS_P9][3][`PFS_CODE_SERIAL]  = SERIAL3_REQUEST_TO_SEND_IN;
    cand[`PFS_P9][4][`PFS_CODE_SERIAL]  = SERIAL4_REQUEST_TO_SEND_IN;
    cand[`PFS_P9][5][`PFS_CODE_SERIAL]  = SERIAL4_CLOCK_OUT_IN;
    cand[`PFS_P9][6][`PFS_CODE_SERIAL]  = SERIAL4_TRANSMIT_IN;
    cand[`PFS_P9][7][`PFS_CODE_SERIAL]  = SERIAL4_BUS_CLOCK_OUT_IN;
    cand[`PFS_P9][1][`PFS_CODE_STX]     = SERIAL3_SIMPLIFIED_TX_IN;
    cand[`PFS_P9][7][`PFS_CODE_STX]     = SERIAL4_SIMPLIFIED_TX_IN;
    cand[`PFS_P9][2][`PFS_CODE_ALT]     = IO_GROUP2_OUT_IN;
    cand[`PFS_P11][0][`PFS_CODE_SER8]   = SERIAL8_TRANSMIT_IN;
    cand[`PFS_P11][1][`PFS_CODE_SER8]   = SERIAL8_CLOCK_OUT_IN;
    cand[`PFS_P11][3][`PFS_CODE_SER8]   = SERIAL8_REQUEST_TO_SEND_IN;
    for (int i = 0; i <= int'(`PFS_P11_LAST_PIN); i++) begin
      cand[`PFS_P11][i][`PFS_CODE_IIO] = INTELLIGENT_IO_GROUP1_IN[i];
    end
    cand[`PFS_P12][0][`PFS_CODE_SERIAL] = SERIAL6_TRANSMIT_IN;
    cand[`PFS_P12][1][`PFS_CODE_SERIAL] = SERIAL6_CLOCK_OUT_IN;
    cand[`PFS_P12][2][`PFS_CODE_SERIAL] = SERIAL6_BUS_CLOCK_OUT_IN;
    cand[`PFS_P12][3][`PFS_CODE_SERIAL] = SERIAL6_REQUEST_TO_SEND_IN;
    cand[`PFS_P12][2][`PFS_CODE_STX]    = SERIAL6_SIMPLIFIED_TX_IN;
    // port 10 offers the port function only
  end

  // ==========================================================================
  // pin multiplexers
  for (genvar p = 0; p < `PFS_NPORTS; p++) begin : g_port
    for (genvar i = 0; i < `PFS_NPINS; i++) begin : g_pin
      pfs_pin_if pif ();
      assign pif.sel   = q.sel[p][i];
      assign pif.latch = q.latch[p][i];
      assign pif.dir   = q.dir[p][i];
      assign pif.od    = q.od[p][i];
      assign pif.cand  = cand[p][i];
      assign mux_out[p][i]  = pif.pin_out;
      assign mux_oe[p][i]   = pif.pin_oe;
      assign ana_flat[p][i] = q.sel[p][i][`PFS_ANA_BIT];
      pfs_pin_mux u_mux (
        .pin (pif.mux)
      );
    end
  end

  // ==========================================================================
  // next state: register access and pin registers
  always_comb begin
    d      = q;
    d.pout = mux_out;
    d.poe  = mux_oe;
    // read data and error are captured in setup so the access phase needs no wait
    if (setup) begin
      d.err   = (dec.grp == pfs_pkg::GRP_NONE) | p9_locked;
      d.rdata = 32'h0000_0000;
      case (dec.grp)
        pfs_pkg::GRP_SEL:   d.rdata[7:0] = q.sel[dec.port][dec.pin];
        pfs_pkg::GRP_LATCH: d.rdata[7:0] = q.latch[dec.port];
        pfs_pkg::GRP_DIR:   d.rdata[7:0] = q.dir[dec.port];
        pfs_pkg::GRP_OD:    d.rdata[7:0] = q.od[dec.port];
        pfs_pkg::GRP_PIN:   d.rdata[7:0] = pin_in[dec.port] & pin_mask(dec.port);
        pfs_pkg::GRP_PROT:  d.rdata[`PFS_PROT_BIT] = q.prot;
        default:            d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_go) begin
      // unlock lasts for exactly one following write to any register but the protect register
      if (dec.grp != pfs_pkg::GRP_PROT) begin
        d.prot = 1'b0;
      end
      if (PSTRB_IN[0] && !q.err) begin
        case (dec.grp)
          pfs_pkg::GRP_SEL:   d.sel[dec.port][dec.pin] = PWDATA_IN[7:0] & `PFS_SEL_MASK;
          pfs_pkg::GRP_LATCH: d.latch[dec.port] = PWDATA_IN[7:0] & pin_mask(dec.port);
          pfs_pkg::GRP_DIR:   d.dir[dec.port]   = PWDATA_IN[7:0] & pin_mask(dec.port);
          pfs_pkg::GRP_OD:    d.od[dec.port]    = PWDATA_IN[7:0] & od_mask(dec.port);
          pfs_pkg::GRP_PROT:  d.prot = PWDATA_IN[`PFS_PROT_BIT];
          default:            d.prot = d.prot;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign PRDATA_OUT      = q.rdata;
  assign PREADY_OUT      = access;
  assign PSLVERR_OUT     = access & q.err;
  assign PORT_PIN_OUT    = q.pout;
  assign PORT_PIN_OE_OUT = q.poe;
  assign ANALOG_SEL_OUT  = ana_flat;

  // ==========================================================================
  // checks
  a_latch_path_p8: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (q.sel[0][3] == `PFS_REG_RESET && q.dir[0][3] && !q.od[0][3])
    |=> PORT_PIN_OUT[3] == $past(q.latch[0][3]) && PORT_PIN_OE_OUT[3])
    else $error("port latch not routed to pin");

  a_input_no_drive: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    1'b1 |=> (PORT_PIN_OE_OUT & ~$past(q.dir)) == 40'h00_0000_0000)
    else $error("pin driven with direction cleared");

  a_od_never_high: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    1'b1 |=> (PORT_PIN_OUT & $past(q.od)) == 40'h00_0000_0000)
    else $error("open drain pin driven high");

  a_analog_no_drive: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (q.sel[1][3] == `PFS_ANALOG_CODE) ##1 (q.sel[1][3] == `PFS_ANALOG_CODE)
    |=> !PORT_PIN_OE_OUT[11])
    else $error("analog pin has its driver on");

  a_p9_lock_hold: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (access && p9_locked) |=> q.sel[1] == $past(q.sel[1]) && !q.prot)
    else $error("locked port 9 select was changed");

  a_unlock_one_shot: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (wr_go && dec.grp != pfs_pkg::GRP_PROT) |=> !q.prot)
    else $error("unlock survived a second write");

  a_p8_can_route: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (q.sel[0][2][2:0] == `PFS_CODE_ALT && q.dir[0][2] && !q.od[0][2] && !q.sel[0][2][7])
    |=> PORT_PIN_OUT[2] == $past(CAN_CONTROLLER_TX_IN))
    else $error("can transmit not on port 8 pin 2");

  a_p9_serial_route: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (q.sel[1][0] == {5'h00, `PFS_CODE_SERIAL} && q.dir[1][0] && !q.od[1][0])
    |=> PORT_PIN_OUT[8] == $past(SERIAL3_CLOCK_OUT_IN))
    else $error("serial 3 clock not on port 9 pin 0");

  a_p9_stx_route: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (q.sel[1][7] == {5'h00, `PFS_CODE_STX} && q.dir[1][7] && !q.od[1][7])
    |=> PORT_PIN_OUT[15] == $past(SERIAL4_SIMPLIFIED_TX_IN))
    else $error("serial 4 simplified tx not on port 9 pin 7");

  a_p10_plain_port: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (q.sel[2][0] == `PFS_REG_RESET && q.dir[2][0])
    |=> PORT_PIN_OUT[16] == $past(q.latch[2][0]) && PORT_PIN_OE_OUT[16])
    else $error("port 10 plain port broken");

  a_p11_iio_route: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (q.sel[3][0] == {5'h00, `PFS_CODE_IIO} && q.dir[3][0] && !q.od[3][0])
    |=> PORT_PIN_OUT[24] == $past(INTELLIGENT_IO_GROUP1_IN[0]))
    else $error("group 1 channel 0 not on port 11 pin 0");

  a_p12_serial_route: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (q.sel[4][1] == {5'h00, `PFS_CODE_SERIAL} && q.dir[4][1] && !q.od[4][1])
    |=> PORT_PIN_OUT[33] == $past(SERIAL6_CLOCK_OUT_IN))
    else $error("serial 6 clock not on port 12 pin 1");

  a_missing_selects: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    q.sel[0][5] == `PFS_REG_RESET && q.sel[3][7:5] == 24'h00_0000)
    else $error("nonexistent select register holds a value");

  a_sel_reserved: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    (setup && dec.grp == pfs_pkg::GRP_SEL) ##1 access
    |-> (PRDATA_OUT & ~{24'h00_0000, `PFS_SEL_MASK}) == 32'h0000_0000)
    else $error("reserved select bits read nonzero");

endmodule

`default_nettype wire

// ===== hdl/pfs_map.svh
// register map, field positions, select codes and reset values of the port function selector
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// ==========================================================================
// ports and pins
`define PFS_NPORTS        5
`define PFS_NPINS         8
`define PFS_P8            3'h0
`define PFS_P9            3'h1
`define PFS_P10           3'h2
`define PFS_P11           3'h3
`define PFS_P12           3'h4
`define PFS_P8_NOSEL_PIN  3'h5
`define PFS_P11_LAST_PIN  3'h4

// ==========================================================================
// byte addresses on the register bus
`define PFS_SEL_BASE      12'h000
`define PFS_SEL_SPAN      12'h0a0
`define PFS_LATCH_BASE    12'h100
`define PFS_DIR_BASE      12'h120
`define PFS_OD_BASE       12'h140
`define PFS_PIN_BASE      12'h160
`define PFS_GRP_SPAN      12'h014
`define PFS_PROT_ADDR     12'h180
`define PFS_ALIGN_MASK    12'h003

// ==========================================================================
// fields and masks
`define PFS_CODE_MSB      2
`define PFS_ANA_BIT       7
`define PFS_PROT_BIT      2
`define PFS_SEL_MASK      8'h87
`define PFS_ANALOG_CODE   8'h80
`define PFS_FULL_MASK     8'hff
`define PFS_P11_MASK      8'h1f
`define PFS_NO_OD_MASK    8'h00
`define PFS_REG_RESET     8'h00

// ==========================================================================
// select codes
`define PFS_CODE_PORT     3'h0
`define PFS_CODE_TIMER    3'h1
`define PFS_CODE_MOTOR    3'h2
`define PFS_CODE_SERIAL   3'h3
`define PFS_CODE_STX      3'h4
`define PFS_CODE_ALT      3'h5
`define PFS_CODE_IIO      3'h6
`define PFS_CODE_SER8     3'h7

`endif

// ===== hdl/pfs_pkg.sv
// types shared by the port function selector modules
`include "pfs_map.svh"

package pfs_pkg;

  // ==========================================================================
  // register groups
  typedef enum logic [2:0] {
    GRP_NONE,
    GRP_SEL,
    GRP_LATCH,
    GRP_DIR,
    GRP_OD,
    GRP_PIN,
    GRP_PROT
  } pfs_grp_e;

  typedef logic [2:0] pfs_code_t;

  typedef struct packed {
    pfs_grp_e   grp;
    logic [2:0] port;
    logic [2:0] pin;
  } pfs_dec_s;

  // ==========================================================================
  // whole state of the top module
  typedef struct packed {
    logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0][7:0] sel;
    logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      latch;
    logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      dir;
    logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      od;
    logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      pout;
    logic [`PFS_NPORTS-1:0][`PFS_NPINS-1:0]      poe;
    logic                                        prot;
    logic [31:0]                                 rdata;
    logic                                        err;
  } pfs_state_s;

endpackage

// ===== hdl/pfs_pin_if.sv
// per-pin carrier between the register block and one pin multiplexer
`timescale 1ns/100ps
`default_nettype none

interface pfs_pin_if;
  logic [7:0] sel;
  logic       latch;
  logic       dir;
  logic       od;
  logic [7:0] cand;
  logic       pin_out;
  logic       pin_oe;

  modport ctrl (output sel, latch, dir, od, cand, input pin_out, pin_oe);
  modport mux  (input sel, latch, dir, od, cand, output pin_out, pin_oe);
endinterface

`default_nettype wire

// ===== hdl/pfs_pin_mux.sv
// one pin: select code, direction and open-drain control to pin level and enable
`timescale 1ns/100ps
`default_nettype none
`include "pfs_map.svh"

module pfs_pin_mux (
  // pin controls and result
  pfs_pin_if.mux pin
);

  pfs_pkg::pfs_code_t code;
  logic               val;
  logic               ana;

  always_comb begin
    code = pin.sel[`PFS_CODE_MSB:0];
    ana  = pin.sel[`PFS_ANA_BIT];
    // unassigned codes find a zero candidate: a quiet low, never garbage
    if (code == `PFS_CODE_PORT) begin
      val = pin.latch;
    end else begin
      val = pin.cand[code];
    end
    // open drain never drives high, only pulls low
    pin.pin_out = pin.od ? 1'b0 : val;
    // analog use keeps the driver off even if direction is left set
    pin.pin_oe  = pin.dir & ~ana & ~(pin.od & val);
  end

endmodule

`default_nettype wire

// ===== test/pfs_periph_model.sv
// partner model: peripheral output lines that feed the pin selector
`timescale 1ns/100ps
`default_nettype none

module pfs_periph_model (
  // level select
  input  wire logic        inv_in,
  // peripheral outputs
  output logic [39:0]      per_out
);
  // ==========================================================================
  // mixed pattern, so a pin routed to a neighbouring line of the other level shows a mismatch
  localparam logic [39:0] PAT = 40'h96_a5c3_3c5a;
  // inversion lets the bench see both levels on every routed line
  assign per_out = PAT ^ {40{inv_in}};
endmodule

`default_nettype wire

// ===== test/tb_port_output_function_select.sv
// self-checking bench for the port output function selector
`timescale 1ns/100ps
`default_nettype none

module tb_port_output_function_select;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] PRDATA_OUT;
  logic        PREADY_OUT;
  logic        PSLVERR_OUT;
  logic [39:0] PORT_PIN_OUT;
  logic [39:0] PORT_PIN_OE_OUT;
  logic [39:0] ANALOG_SEL_OUT;
  logic [39:0] pv;
  logic        inv;
  logic [31:0] rd;
  logic        er;
  int          failures;
  int          cmp_count;
  int          p;
  int          b;
  // port, pin, code, peripheral line index
  localparam logic [19:0] ROWS [29] = '{
    20'h00100, 20'h00201, 20'h0030e, 20'h0040f, 20'h01202, 20'h01310, 20'h0161f,
    20'h02503, 20'h10304, 20'h11305, 20'h12306, 20'h13308, 20'h1430d, 20'h15309,
    20'h1630b, 20'h1730a, 20'h11407, 20'h1740c, 20'h12519, 20'h30716, 20'h31717,
    20'h33718, 20'h3061a, 20'h3461e, 20'h40311, 20'h41312, 20'h42313, 20'h43315,
    20'h42414};
  localparam logic [39:0] PIN_LVL = 40'h3c_1234_a55a;

  pfs_periph_model u_pfs_periph_model (.inv_in(inv), .per_out(pv));

  pfs_port_mux_top u_pfs_port_mux_top (
    .CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hf),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .PORT_PIN_IN(PIN_LVL), .PORT_PIN_OUT(PORT_PIN_OUT), .PORT_PIN_OE_OUT(PORT_PIN_OE_OUT),
    .ANALOG_SEL_OUT(ANALOG_SEL_OUT), .TIMER_A4_OUTPUT_IN(pv[0]), .MOTOR_PHASE_U_IN(pv[1]),
    .MOTOR_PHASE_U_INV_IN(pv[2]), .CAN_CONTROLLER_TX_IN(pv[3]),
    .SERIAL3_CLOCK_OUT_IN(pv[4]), .SERIAL3_BUS_CLOCK_OUT_IN(pv[5]),
    .SERIAL3_TRANSMIT_IN(pv[6]), .SERIAL3_SIMPLIFIED_TX_IN(pv[7]),
    .SERIAL3_REQUEST_TO_SEND_IN(pv[8]), .SERIAL4_CLOCK_OUT_IN(pv[9]),
    .SERIAL4_BUS_CLOCK_OUT_IN(pv[10]), .SERIAL4_TRANSMIT_IN(pv[11]),
    .SERIAL4_SIMPLIFIED_TX_IN(pv[12]), .SERIAL4_REQUEST_TO_SEND_IN(pv[13]),
    .SERIAL5_BUS_CLOCK_OUT_IN(pv[14]), .SERIAL5_SIMPLIFIED_TX_IN(pv[15]),
    .SERIAL5_REQUEST_TO_SEND_IN(pv[16]), .SERIAL6_TRANSMIT_IN(pv[17]),
    .SERIAL6_CLOCK_OUT_IN(pv[18]), .SERIAL6_BUS_CLOCK_OUT_IN(pv[19]),
    .SERIAL6_SIMPLIFIED_TX_IN(pv[20]), .SERIAL6_REQUEST_TO_SEND_IN(pv[21]),
    .SERIAL8_TRANSMIT_IN(pv[22]), .SERIAL8_CLOCK_OUT_IN(pv[23]),
    .SERIAL8_REQUEST_TO_SEND_IN(pv[24]), .IO_GROUP2_OUT_IN(pv[25]),
    .INTELLIGENT_IO_GROUP1_IN(pv[33:26]));

  // ==========================================================================
  // report and bus tasks
  task automatic stop_test;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s exp %b got %b", n, e, g);
    end
  endtask

  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (PREADY_OUT === 1'b1) break;
    end
    rd      = PRDATA_OUT;
    er      = PSLVERR_OUT;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic sel_wr(input int sp, input int sb, input logic [7:0] v);
    if (sp == 1) apb(1'b1, 12'h180, 32'h4);
    apb(1'b1, 12'(sp * 32 + sb * 4), {24'h0, v});
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  // ==========================================================================
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; inv = 1'b0; failures = 0; cmp_count = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk_pin("oe reset", 1'b0, |PORT_PIN_OE_OUT);
    apb(1'b0, 12'h000, 32'h0);
    chk_word("sel reset", 32'h0, rd);
    for (p = 0; p < 5; p++) apb(1'b1, 12'(12'h120 + p * 4), 32'hff);
    for (int i = 0; i < 29; i++) begin
      p = int'(ROWS[i][19:16]);
      b = int'(ROWS[i][15:12]);
      sel_wr(p, b, {5'h0, ROWS[i][10:8]});
      for (int k = 0; k < 2; k++) begin
        inv <= k[0];
        settle();
        chk_pin("route", pv[ROWS[i][7:0]], PORT_PIN_OUT[p*8+b]);
      end
      chk_pin("route oe", 1'b1, PORT_PIN_OE_OUT[p*8+b]);
      sel_wr(p, b, 8'h00);
    end
    // unused bits and the analog flag of a select register
    apb(1'b1, 12'h00c, 32'hff);
    apb(1'b0, 12'h00c, 32'h0);
    chk_word("sel mask", 32'h87, rd);
    apb(1'b1, 12'h00c, 32'h0);
    // latch path and open drain on port 12, then the latch path on port 10
    apb(1'b1, 12'h110, 32'h05);
    settle();
    chk_pin("latch hi", 1'b1, PORT_PIN_OUT[32]);
    chk_pin("latch lo", 1'b0, PORT_PIN_OUT[33]);
    apb(1'b1, 12'h150, 32'h03);
    settle();
    chk_pin("od high off", 1'b0, PORT_PIN_OE_OUT[32]);
    chk_pin("od low on", 1'b1, PORT_PIN_OE_OUT[33]);
    apb(1'b1, 12'h108, 32'h01);
    settle();
    chk_pin("p10 port", 1'b1, PORT_PIN_OUT[16]);
    chk_pin("p10 port oe", 1'b1, PORT_PIN_OE_OUT[16]);
    // analog codes on ports 10 and 9 release the driver
    apb(1'b1, 12'h040, 32'h80);
    sel_wr(1, 3, 8'h80);
    settle();
    chk_pin("p10 analog", 1'b1, ANALOG_SEL_OUT[16]);
    chk_pin("p10 an oe", 1'b0, PORT_PIN_OE_OUT[16]);
    chk_pin("p9 analog", 1'b1, ANALOG_SEL_OUT[11]);
    chk_pin("p9 an oe", 1'b0, PORT_PIN_OE_OUT[11]);
    // port 9 select protection, including an unlock spent on another write
    apb(1'b1, 12'h020, 32'h3);
    chk_pin("locked err", 1'b1, er);
    apb(1'b1, 12'h180, 32'h4);
    apb(1'b0, 12'h180, 32'h0);
    chk_word("prot read", 32'h4, rd);
    apb(1'b1, 12'h100, 32'h0);
    apb(1'b1, 12'h020, 32'h3);
    chk_pin("spent err", 1'b1, er);
    apb(1'b0, 12'h020, 32'h0);
    chk_word("locked sel", 32'h0, rd);
    sel_wr(1, 0, 8'h03);
    chk_pin("unlocked", 1'b0, er);
    apb(1'b0, 12'h020, 32'h0);
    chk_word("unlocked sel", 32'h3, rd);
    // input direction and pin level readback
    apb(1'b1, 12'h124, 32'h0);
    settle();
    chk_pin("input oe", 1'b0, PORT_PIN_OE_OUT[8]);
    apb(1'b0, 12'h164, 32'h0);
    chk_word("pin level", {24'h0, PIN_LVL[15:8]}, rd);
    // missing select registers and a misaligned address
    apb(1'b0, 12'h014, 32'h0);
    chk_pin("p8 pin5", 1'b1, er);
    apb(1'b0, 12'h074, 32'h0);
    chk_pin("p11 pin5", 1'b1, er);
    apb(1'b0, 12'h001, 32'h0);
    chk_pin("misaligned", 1'b1, er);
    // tolerant port 8 pins rely on a writable open-drain bit
    apb(1'b1, 12'h140, 32'h0f);
    apb(1'b0, 12'h140, 32'h0);
    chk_word("p8 od", 32'h0f, rd);
    stop_test();
  end
endmodule

`default_nettype wire
